// File: common/lcem_pkg.sv
// shared constants and carrier types for the link checksum and error monitor
package lcem_pkg;
   localparam logic [11:0] LCEM_ADDR_CHECKSUM  = 12'h45D;
   localparam logic [11:0] LCEM_ADDR_MONITOR   = 12'h46B;
   localparam logic [7:0]  LCEM_CHECKSUM_RESET = 8'h45;
   localparam logic [7:0]  LCEM_MONITOR_RESET  = 8'h00;
   localparam int          LCEM_LANE_HI        = 6;
   localparam int          LCEM_LANE_LO        = 4;
   localparam int          LCEM_TYPE_HI        = 1;
   localparam int          LCEM_TYPE_LO        = 0;
   localparam int          LCEM_LANES          = 8;
   localparam int          LCEM_TYPES          = 3;
   localparam logic [7:0]  LCEM_COUNT_MAX      = 8'hFF;
   localparam logic [2:0]  LCEM_LANE_RESET     = 3'h0;
   localparam logic [1:0]  LCEM_TYPE_RESET     = 2'h0;

   typedef enum logic [1:0] {
      LCEM_CNT_BAD_DISPARITY = 2'b00,
      LCEM_CNT_NOT_IN_TABLE  = 2'b01,
      LCEM_CNT_UNEXP_CONTROL = 2'b10
   } lcem_cnt_type_t;

   // register access request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } lcem_req_t;

   // per-lane error events, one bit per lane
   typedef struct packed {
      logic [7:0] bad_disparity;
      logic [7:0] not_in_table;
      logic [7:0] unexpected_control;
   } lcem_err_t;

   // whole block state
   typedef struct packed {
      logic [7:0]                 lane0_config_sum;
      logic [2:0]                 monitor_lane_index;
      logic [1:0]                 counter_type_select;
      logic [7:0][2:0][7:0]       counts;
      logic [7:0]                 rdata;
      logic                       rvalid;
   } lcem_state_t;
endpackage

// File: core/lcem_top.sv
// link checksum register and indirect per-lane error counter readback
// What this block does
// (R1) software writes lane 0 checksum: byte sum of 0x450..0x45C modulo 256
// (R2) three error counters per lane, reachable only through lane and type select
// (R3) lane field bits 6:4 picks lane n for value n, 0 through 7
// (R4) type field bits 1:0: 0 disparity, 1 not-in-table, 2 unexpected control
// (R5) software writes lane and type first, then reads monitor register
// (R6) monitor read returns selected counter on all eight bits
// (R7) lane and type selects are write-only, reset to zero
// (R8) reserved monitor bits ignore writes; uncovered reserved bits read zero
`timescale 1ns/1ns
module lcem_top (
   // clock and reset
   input  wire  logic                ref_clk,
   input  wire  logic                reset,
   // register access
   input  wire  lcem_pkg::lcem_req_t reg_req,
   output logic [7:0]                reg_rdata,
   output logic                      reg_rvalid,
   // link error events
   input  wire  lcem_pkg::lcem_err_t lane_errors,
   // configuration out
   output logic [7:0]                lane0_config_sum
);
   import lcem_pkg::*;

   // register state and its next value
   lcem_state_t state;
   lcem_state_t next_state;
   lcem_state_t counted_state;
   lcem_state_t written_state;

   // register an address falls on
   typedef enum logic [1:0] {
      LCEM_HIT_NONE     = 2'b00,
      LCEM_HIT_CHECKSUM = 2'b01,
      LCEM_HIT_MONITOR  = 2'b10
   } lcem_hit_t;

   // address decode shared by writes and reads
   function automatic lcem_hit_t decode_addr(input logic [11:0] addr);
      if (addr == LCEM_ADDR_CHECKSUM) begin
         decode_addr = LCEM_HIT_CHECKSUM;
      end else if (addr == LCEM_ADDR_MONITOR) begin
         decode_addr = LCEM_HIT_MONITOR;
      end else begin
         decode_addr = LCEM_HIT_NONE;
      end
   endfunction

   // (R3) lane index field of a monitor write
   function automatic logic [2:0] lane_field(input logic [7:0] wdata);
      lane_field = wdata[LCEM_LANE_HI:LCEM_LANE_LO];
   endfunction

   // (R4) counter type field of a monitor write
   function automatic logic [1:0] type_field(input logic [7:0] wdata);
      type_field = wdata[LCEM_TYPE_HI:LCEM_TYPE_LO];
   endfunction

   // saturate rather than wrap, so a busy lane never reads as clean
   function automatic logic [7:0] sat_inc(
      input logic [7:0] v,
      input logic       ev
   );
      if (ev && v != LCEM_COUNT_MAX) begin
         sat_inc = v + 8'h01;
      end else begin
         sat_inc = v;
      end
   endfunction

   // event lines of one counter type, bit n for lane n
   function automatic logic [7:0] events_of_type(
      input lcem_err_t  e,
      input logic [1:0] typ
   );
      case (typ)
         LCEM_CNT_BAD_DISPARITY: begin
            events_of_type = e.bad_disparity;
         end
         LCEM_CNT_NOT_IN_TABLE: begin
            events_of_type = e.not_in_table;
         end
         LCEM_CNT_UNEXP_CONTROL: begin
            events_of_type = e.unexpected_control;
         end
         default: begin
            events_of_type = 8'h00;
         end
      endcase
   endfunction

   // (R2) three counters kept per lane
   function automatic lcem_state_t count_events(
      input lcem_state_t st,
      input lcem_err_t   e
   );
      lcem_state_t res;
      logic [7:0]  ev;
      res = st;
      ev  = 8'h00;
      for (int t = 0; t < LCEM_TYPES; t++) begin
         ev = events_of_type(e, 2'(t));
         for (int l = 0; l < LCEM_LANES; l++) begin
            res.counts[l][t] = sat_inc(st.counts[l][t], ev[l]);
         end
      end
      count_events = res;
   endfunction

   // (R4) one of a lane's three counters by type code
   function automatic logic [7:0] lane_counter(
      input logic [2:0][7:0] lane_counts,
      input logic [1:0]      typ
   );
      case (typ)
         LCEM_CNT_BAD_DISPARITY: begin
            lane_counter = lane_counts[0];
         end
         LCEM_CNT_NOT_IN_TABLE: begin
            lane_counter = lane_counts[1];
         end
         LCEM_CNT_UNEXP_CONTROL: begin
            lane_counter = lane_counts[2];
         end
         default: begin
            lane_counter = 8'h00;
         end
      endcase
   endfunction

   // (R3) counters of the selected lane
   function automatic logic [7:0] pick_count(input lcem_state_t st);
      pick_count = lane_counter(st.counts[st.monitor_lane_index], st.counter_type_select);
   endfunction

   // register writes
   function automatic lcem_state_t apply_write(
      input lcem_state_t st,
      input lcem_req_t   req
   );
      lcem_state_t res;
      res = st;
      if (req.wr) begin
         case (decode_addr(req.addr))
            // (R1) checksum is stored as written
            LCEM_HIT_CHECKSUM: begin
               res.lane0_config_sum = req.wdata;
            end
            // (R8) only the select fields take writes
            LCEM_HIT_MONITOR: begin
               res.monitor_lane_index  = lane_field(req.wdata);
               res.counter_type_select = type_field(req.wdata);
            end
            // other addresses take no writes
            default: begin
               res.lane0_config_sum = st.lane0_config_sum;
            end
         endcase
      end
      apply_write = res;
   endfunction

   // (R6) read data of one register
   function automatic logic [7:0] read_word(
      input lcem_state_t st,
      input logic [11:0] addr
   );
      case (decode_addr(addr))
         LCEM_HIT_CHECKSUM: begin
            read_word = st.lane0_config_sum;
         end
         // (R7) selects are not readable, only the chosen count
         LCEM_HIT_MONITOR: begin
            read_word = pick_count(st);
         end
         // unmapped addresses read zero
         default: begin
            read_word = 8'h00;
         end
      endcase
   endfunction

   // register reads, answered one cycle later
   function automatic lcem_state_t apply_read(
      input lcem_state_t cur,
      input lcem_state_t nxt,
      input lcem_req_t   req
   );
      lcem_state_t res;
      res        = nxt;
      res.rvalid = req.rd;
      if (req.rd) begin
         res.rdata = read_word(cur, req.addr);
      end
      apply_read = res;
   endfunction

   // counting, then writes, then reads of the old state
   always_comb begin
      counted_state = count_events(state, lane_errors);
      written_state = apply_write(counted_state, reg_req);
      next_state    = apply_read(state, written_state, reg_req);
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state                     <= '0;
         state.lane0_config_sum    <= LCEM_CHECKSUM_RESET;
         // (R7) selects reset to lane 0, disparity
         state.monitor_lane_index  <= LCEM_LANE_RESET;
         state.counter_type_select <= LCEM_TYPE_RESET;
         state.rdata               <= LCEM_MONITOR_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata        = state.rdata;
   assign reg_rvalid       = state.rvalid;
   assign lane0_config_sum = state.lane0_config_sum;
endmodule

// File: verif/lcem_top_sva.sv
// port checker for the checksum and error monitor
`timescale 1ns/1ns
module lcem_top_sva (
   // clock, reset and observed ports
   input wire logic [7:0]          lane0_config_sum,
   input wire logic                ref_clk,
   input wire logic                reset,
   input wire lcem_pkg::lcem_req_t reg_req,
   input wire logic [7:0]          reg_rdata,
   input wire logic                reg_rvalid
);
   import lcem_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   wire cs = reg_req.addr == LCEM_ADDR_CHECKSUM;
   wire mon = reg_req.addr == LCEM_ADDR_MONITOR;
   // counter type last written to the monitor register
   logic [1:0] type_seen;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         type_seen <= LCEM_TYPE_RESET;
      end else if (reg_req.wr && mon) begin
         type_seen <= reg_req.wdata[LCEM_TYPE_HI:LCEM_TYPE_LO];
      end
   end
   property p_rv; 1 |-> reg_rvalid == ($past(reg_req.rd) && !$past(reset)); endproperty
   a_rv: assert property (p_rv) else $error("rvalid not one cycle after read");
   property p_ck; reg_req.rd && cs |=> reg_rdata == $past(lane0_config_sum); endproperty
   a_ck: assert property (p_ck) else $error("checksum readback wrong");
   property p_um; reg_req.rd && !cs && !mon |=> reg_rdata == 8'h00; endproperty
   a_um: assert property (p_um) else $error("unmapped read not zero");
   property p_hd; !reg_req.rd |=> $stable(reg_rdata); endproperty
   a_hd: assert property (p_hd) else $error("read data moved");
   property p_wr; reg_req.wr && cs |=> lane0_config_sum == $past(reg_req.wdata); endproperty
   a_wr: assert property (p_wr) else $error("checksum write lost");
   property p_rs;
      disable iff (1'b0) reset |=>
         lane0_config_sum == LCEM_CHECKSUM_RESET && !reg_rvalid && reg_rdata == LCEM_MONITOR_RESET;
   endproperty
   a_rs: assert property (p_rs) else $error("bad reset value");
   property p_t3;
      reg_req.rd && mon && type_seen == 2'h3 |=> reg_rdata == 8'h00;
   endproperty
   a_t3: assert property (p_t3) else $error("unused counter type read not zero");
   cover property (reg_req.rd && mon ##1 reg_rdata != 8'h00);
   cover property (reg_req.rd && mon ##1 reg_rdata == LCEM_COUNT_MAX);
   cover property (reg_req.wr && mon);
   cover property (reg_req.wr && cs);
endmodule

// File: verif/lcem_tx_model.sv
// link transmitter model pulsing per-lane error events
`timescale 1ns/1ns
module lcem_tx_model (
   // clock and error events
   input wire logic            ref_clk,
   output lcem_pkg::lcem_err_t lane_errors
);
   initial lane_errors = '0;
   task automatic send(input int k, input int ln, input int n);
      repeat (n) begin
         @(negedge ref_clk);
         lane_errors[(2 - k) * 8 + ln] = 1'b1;
         @(negedge ref_clk);
         lane_errors = '0;
      end
   endtask
endmodule

// File: verif/lcem_top_tb.sv
// testbench for the checksum and error monitor
`timescale 1ns/1ns
module lcem_top_tb;
   import lcem_pkg::*;
   logic ref_clk = 0, reset = 1, reg_rvalid;
   lcem_req_t reg_req = '0;
   lcem_err_t lane_errors;
   logic [7:0] reg_rdata, lane0_config_sum;
   int mismatches = 0, compares = 0, cyc = 0;
   always #25 ref_clk = ~ref_clk;
   lcem_top dut_u (.ref_clk(ref_clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .lane_errors(lane_errors), .lane0_config_sum(lane0_config_sum));
   lcem_tx_model tx_u (.ref_clk(ref_clk), .lane_errors(lane_errors));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge ref_clk) if (++cyc == 5000) begin
      mismatches++;
      final_report();
   end
   task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_req = '{w, !w, a, d};
      @(negedge ref_clk);
      reg_req = '0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      // answer stands in the cycle after the strobe
      chk({7'h00, reg_rvalid}, 8'h01);
      chk(reg_rdata, exp);
   endtask
   initial begin
      logic [7:0] sum;
      sum = 8'h00;
      repeat (4) @(negedge ref_clk);
      reset = 0;
      chk(lane0_config_sum, LCEM_CHECKSUM_RESET);
      rd(LCEM_ADDR_MONITOR, 8'h00);
      // link parameter bytes 0x50..0x5C summed modulo 256
      for (int i = 0; i < 13; i++) sum = sum + 8'(8'h50 + i);
      acc(1'b1, LCEM_ADDR_CHECKSUM, sum);
      chk(lane0_config_sum, sum);
      rd(LCEM_ADDR_CHECKSUM, sum);
      rd(12'h46C, 8'h00);
      for (int t = 0; t < 3; t++)
         for (int l = 0; l < 8; l++) tx_u.send(t, l, l + t * 8 + 1);
      for (int t = 0; t < 4; t++)
         for (int l = 0; l < 8; l++) begin
            acc(1'b1, LCEM_ADDR_MONITOR, 8'h8C | 8'(l << 4) | 8'(t));
            rd(LCEM_ADDR_MONITOR, t == 3 ? 8'h00 : 8'(l + t * 8 + 1));
         end
      // push lane 7 unexpected control past the top of the range
      tx_u.send(2, 7, 240);
      acc(1'b1, LCEM_ADDR_MONITOR, 8'h72);
      rd(LCEM_ADDR_MONITOR, LCEM_COUNT_MAX);
      // mid-run reset with lane 7 still selected
      @(negedge ref_clk) reset = 1;
      repeat (4) @(negedge ref_clk);
      reset = 0;
      tx_u.send(0, 0, 2);
      tx_u.send(1, 3, 5);
      rd(LCEM_ADDR_MONITOR, 8'h02);
      acc(1'b1, LCEM_ADDR_MONITOR, 8'h31);
      rd(LCEM_ADDR_MONITOR, 8'h05);
      rd(LCEM_ADDR_CHECKSUM, LCEM_CHECKSUM_RESET);
      chk(lane0_config_sum, LCEM_CHECKSUM_RESET);
      final_report();
   end
endmodule
bind lcem_top lcem_top_sva sva_u (.ref_clk(ref_clk), .reset(reset), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .lane0_config_sum(lane0_config_sum));
